// ==== common/win_defs.svh ====
`ifndef WIN_DEFS_SVH
`define WIN_DEFS_SVH

// ****************************************
// Widths
// ****************************************
`define ADDR_W      16
`define WSEL_W      8
`define PHYS_W      10

// ****************************************
// Window encodings (select bits 6:3, 6:4, 6:5)
// ****************************************
`define W128_TAG    4'h2
`define W64_TAG     3'h2
`define W32_TAG     2'h2

// ****************************************
// Window position in the lower register file
// ****************************************
`define LOW128      1'h1
`define LOW64       2'h3
`define LOW32       3'h7
`define LOWER_PAGE  8'h00
`define PAD6        6'h00

// ****************************************
// Address map bounds
// ****************************************
`define SFR_TOP     16'h0017
`define RAM_TOP     16'h03FF
`define EXT_LO_TOP  16'h1FFD
`define PORT_TOP    16'h1FFF
`define ROM_TOP     16'h9FFF
`define ADDR_RST    16'h0000

`endif

// ==== common/win_pkg.sv ====
package win_pkg;

    // Address space regions
    typedef enum logic [2:0] {
        REGION_SFR,
        REGION_RAM,
        REGION_EXT,
        REGION_PORT,
        REGION_INTPROG
    } region_t;

endpackage

// ==== common/win_if.sv ====
`timescale 1ns/10ps
`include "win_defs.svh"

// Lower address and window select in, remapped RAM address out
interface win_if;
    logic [7:0]           low_addr;   // Low byte of CPU address
    logic [`WSEL_W-1:0]   wsel;       // Window select value
    logic                 hit;        // Address falls in active window
    logic [`PHYS_W-1:0]   phys;       // Remapped register RAM address

    modport calc (input low_addr, input wsel, output hit, output phys);
    modport user (output low_addr, output wsel, input hit, input phys);
endinterface

// ==== logic/window_calc.sv ====
`timescale 1ns/10ps
`include "win_defs.svh"

// ****************************************
// Window remap calculation
// ****************************************
module window_calc (
    win_if.calc w
);

    // index bits span all RAM
    // Decode the three window sizes; bit 7 of the select is a don't care
    always_comb begin
        w.hit  = 1'b0;
        w.phys = '0;
        if (w.wsel[6:3] == `W128_TAG && w.low_addr[7] == `LOW128) begin
            w.hit  = 1'b1;
            w.phys = {w.wsel[2:0], w.low_addr[6:0]};
        end
        else if (w.wsel[6:4] == `W64_TAG && w.low_addr[7:6] == `LOW64) begin
            w.hit  = 1'b1;
            w.phys = {w.wsel[3:0], w.low_addr[5:0]};
        end
        else if (w.wsel[6:5] == `W32_TAG && w.low_addr[7:5] == `LOW32) begin
            w.hit  = 1'b1;
            w.phys = {w.wsel[4:0], w.low_addr[4:0]};
        end
    end

endmodule

// ==== logic/register_window_remap.sv ====
`timescale 1ns/10ps
`include "win_defs.svh"

module register_window_remap (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    // CPU request
    input  wire logic                 addr_valid,
    input  wire logic [`ADDR_W-1:0]   cpu_addr,
    input  wire logic                 is_fetch,
    // Configuration
    input  wire logic [`WSEL_W-1:0]   window_select_value,
    input  wire logic                 external_access_select,
    // Decoded result
    output logic                      valid_r,
    output logic [`ADDR_W-1:0]        mem_addr_r,
    output win_pkg::region_t          region_r,
    output logic                      remapped_r
);
    import win_pkg::*;

    // ****************************************
    // Window calculation
    // ****************************************

    win_if w ();                        // Link to the window calculator
    logic               lower_file;     // Address inside 00H-FFH
    logic               use_window;     // Data access that hits a window
    logic [`ADDR_W-1:0] mem_addr_nxt;   // Effective address
    region_t            region_nxt;     // Region of that address

    assign w.low_addr = cpu_addr[7:0];
    assign w.wsel     = window_select_value;

    window_calc u_calc (
        .w (w.calc)
    );

    // Only data accesses in the lower file are windowed
    assign lower_file = (cpu_addr[15:8] == `LOWER_PAGE);
    assign use_window = lower_file && w.hit && !is_fetch;

    // ****************************************
    // Address selection
    // ****************************************

    // Remapped or direct address
    always_comb begin
        if (use_window) begin
            mem_addr_nxt = {`PAD6, w.phys};
        end
        else begin
            mem_addr_nxt = cpu_addr;
        end
    end

    // ****************************************
    // Region classification
    // ****************************************

    // Classify the effective address
    always_comb begin
        // code in register space forced off-chip
        if (is_fetch && cpu_addr <= `RAM_TOP) begin
            region_nxt = REGION_EXT;
        end
        else if (mem_addr_nxt <= `SFR_TOP) begin
            region_nxt = REGION_SFR;
        end
        else if (mem_addr_nxt <= `RAM_TOP) begin
            region_nxt = REGION_RAM;
        end
        else if (mem_addr_nxt <= `EXT_LO_TOP) begin
            region_nxt = REGION_EXT;
        end
        // On-chip ports
        else if (mem_addr_nxt <= `PORT_TOP) begin
            region_nxt = REGION_PORT;
        end
        // program memory chosen by access select
        else if (mem_addr_nxt <= `ROM_TOP) begin
            region_nxt = external_access_select ? REGION_INTPROG : REGION_EXT;
        end
        else begin
            region_nxt = REGION_EXT;
        end
    end

    // ****************************************
    // Output registers
    // ****************************************

    // Result valid one cycle after request
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= addr_valid;
        end
    end

    // Effective address
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mem_addr_r <= `ADDR_RST;
        end else if (addr_valid) begin
            mem_addr_r <= mem_addr_nxt;
        end
    end

    // Region
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            region_r <= REGION_SFR;
        end else if (addr_valid) begin
            region_r <= region_nxt;
        end
    end

    // Remap flag
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            remapped_r <= 1'b0;
        end else if (addr_valid) begin
            remapped_r <= use_window;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // Data request in each window
    sequence s_w128;
        addr_valid && !is_fetch && cpu_addr[15:7] == {`LOWER_PAGE, `LOW128}
            && window_select_value[6:3] == `W128_TAG;
    endsequence

    sequence s_w64;
        addr_valid && !is_fetch && cpu_addr[15:6] == {`LOWER_PAGE, `LOW64}
            && window_select_value[6:4] == `W64_TAG;
    endsequence

    sequence s_w32;
        addr_valid && !is_fetch && cpu_addr[15:5] == {`LOWER_PAGE, `LOW32}
            && window_select_value[6:5] == `W32_TAG;
    endsequence

    // Request that no window remaps: fetch, outside the lower file, or no window hit
    sequence s_direct;
        addr_valid && (is_fetch || !lower_file
            || !(window_select_value[6:3] == `W128_TAG && cpu_addr[7] == `LOW128)
            && !(window_select_value[6:4] == `W64_TAG && cpu_addr[7:6] == `LOW64)
            && !(window_select_value[6:5] == `W32_TAG && cpu_addr[7:5] == `LOW32));
    endsequence

    property p_win128;
        s_w128 |=> remapped_r && valid_r && mem_addr_r ==
            {`PAD6, $past(window_select_value[2:0]), $past(cpu_addr[6:0])};
    endproperty
    a_win128: assert property (p_win128) else $error("128-byte window wrong");

    property p_win64;
        s_w64 |=> remapped_r && mem_addr_r ==
            {`PAD6, $past(window_select_value[3:0]), $past(cpu_addr[5:0])};
    endproperty
    a_win64: assert property (p_win64) else $error("64-byte window wrong");

    property p_win32;
        s_w32 |=> remapped_r && mem_addr_r ==
            {`PAD6, $past(window_select_value[4:0]), $past(cpu_addr[4:0])};
    endproperty
    a_win32: assert property (p_win32) else $error("32-byte window wrong");

    property p_reach;
        remapped_r |-> mem_addr_r <= `RAM_TOP && region_r != REGION_EXT;
    endproperty
    a_reach: assert property (p_reach) else $error("Window beyond register RAM");

    property p_fetch_ext;
        addr_valid && is_fetch && cpu_addr <= `RAM_TOP
            |=> region_r == REGION_EXT && !remapped_r;
    endproperty
    a_fetch_ext: assert property (p_fetch_ext) else $error("Fetch not sent off-chip");

    property p_prog;
        addr_valid && cpu_addr > `PORT_TOP && cpu_addr <= `ROM_TOP
            |=> region_r == ($past(external_access_select) ? REGION_INTPROG : REGION_EXT);
    endproperty
    a_prog: assert property (p_prog) else $error("Program memory select wrong");

    property p_sfr_ram;
        valid_r && !remapped_r && $past(!is_fetch) |->
            (region_r == REGION_SFR) == (mem_addr_r <= `SFR_TOP)
            && (region_r == REGION_RAM) == (mem_addr_r > `SFR_TOP && mem_addr_r <= `RAM_TOP);
    endproperty
    a_sfr_ram: assert property (p_sfr_ram) else $error("SFR or RAM decode wrong");

    property p_ext;
        addr_valid && (cpu_addr > `ROM_TOP || cpu_addr > `RAM_TOP && cpu_addr <= `EXT_LO_TOP)
            |=> region_r == REGION_EXT;
    endproperty
    a_ext: assert property (p_ext) else $error("External range not external");

    property p_direct;
        s_direct |=> !remapped_r ##0 mem_addr_r == $past(cpu_addr);
    endproperty
    a_direct: assert property (p_direct) else $error("Unwindowed access remapped");

endmodule

// ==== verif/cpu_model.sv ====
`timescale 1ns/10ps
// ****************************************
// CPU address source
// ****************************************
module cpu_model (
    // Clock
    input  wire logic        sys_clk,
    // Request lines
    output logic             addr_valid,
    output logic [15:0]      cpu_addr,
    output logic             is_fetch,
    output logic [7:0]       window_select_value,
    output logic             external_access_select
);
    // Quiet bus at time zero
    initial begin
        addr_valid = 1'b0;
        cpu_addr = 16'h0000;
        is_fetch = 1'b0;
        window_select_value = 8'h00;
        external_access_select = 1'b0;
    end
    function automatic logic reserved(input logic [15:0] a);
        return (a >= 16'h2014 && a <= 16'h2017) || (a >= 16'h2019 && a <= 16'h201F)
            || (a >= 16'h205E && a <= 16'h207F);
    endfunction
    task automatic issue(input logic [15:0] a, input logic f, input logic [7:0] w,
                         input logic e);
        @(negedge sys_clk);
        addr_valid = 1'b1;
        cpu_addr = a;
        is_fetch = f;
        window_select_value = w;
        external_access_select = e;
    endtask
    // Drop strobe, scramble stale qualifiers
    task automatic idle();
        @(negedge sys_clk);
        addr_valid = 1'b0;
        cpu_addr = ~cpu_addr;
        is_fetch = ~is_fetch;
        window_select_value = ~window_select_value;
    endtask
endmodule

// ==== verif/register_window_remap_tb_top.sv ====
`timescale 1ns/10ps
// ****************************************
// Bench top
// ****************************************
module register_window_remap_tb_top;
    import win_pkg::*;
    logic sys_clk, reset, addr_valid, is_fetch, external_access_select;
    logic [15:0] cpu_addr, mem_addr_r;
    logic [7:0] window_select_value;
    logic valid_r, remapped_r;
    region_t region_r;
    logic [19:0] exp_q[$];           // Expected {remap, region, addr}
    logic [19:0] last, ex;           // Last result, popped note
    logic [7:0] lows[7] = '{8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hDF, 8'hE0, 8'hFF};
    logic [15:0] bnd[14] = '{16'h0000, 16'h0017, 16'h0018, 16'h03FF, 16'h0400, 16'h1FFD,
        16'h1FFE, 16'h1FFF, 16'h2000, 16'h2013, 16'h2080, 16'h9FFF, 16'hA000, 16'hFFFF};
    int n_errors = 0, num_checks = 0, cycles = 0;
    logic [15:0] ra;
    int s;
    cpu_model cpu_model_i (.sys_clk(sys_clk), .addr_valid(addr_valid), .cpu_addr(cpu_addr),
        .is_fetch(is_fetch), .window_select_value(window_select_value),
        .external_access_select(external_access_select));
    register_window_remap register_window_remap_i (.sys_clk(sys_clk), .reset(reset),
        .addr_valid(addr_valid), .cpu_addr(cpu_addr), .is_fetch(is_fetch),
        .window_select_value(window_select_value),
        .external_access_select(external_access_select), .valid_r(valid_r),
        .mem_addr_r(mem_addr_r), .region_r(region_r), .remapped_r(remapped_r));
    // Clock, 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Expected decode of one request
    function automatic logic [19:0] model(input logic [15:0] a, input logic f,
                                          input logic [7:0] w, input logic e);
        logic [15:0] x;
        logic        m;
        region_t     r;
        x = a;
        m = !f && a[15:8] == 8'h00;
        if (m && w[6:3] == 4'h2 && a[7]) x = {6'h00, w[2:0], a[6:0]};
        else if (m && w[6:4] == 3'h2 && a[7:6] == 2'h3) x = {6'h00, w[3:0], a[5:0]};
        else if (m && w[6:5] == 2'h2 && a[7:5] == 3'h7) x = {6'h00, w[4:0], a[4:0]};
        else m = 1'b0;
        if (f && a <= 16'h03FF) r = REGION_EXT;
        else if (x <= 16'h0017) r = REGION_SFR;
        else if (x <= 16'h03FF) r = REGION_RAM;
        else if (x <= 16'h1FFD) r = REGION_EXT;
        else if (x <= 16'h1FFF) r = REGION_PORT;
        else if (x <= 16'h9FFF) r = e ? REGION_INTPROG : REGION_EXT;
        else r = REGION_EXT;
        return {m, r, x};
    endfunction
    // Compare and count
    task automatic check(input string nm, input logic [20:0] seen, input logic [20:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Note expectation, then drive
    task automatic req(input logic [15:0] a, input logic f, input logic [7:0] w,
                       input logic e);
        exp_q.push_back(model(a, f, w, e));
        cpu_model_i.issue(a, f, w, e);
    endtask
    task automatic close_out();
        if (exp_q.size() != 0) n_errors++;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watch outputs, settled at falling edge
    always @(negedge sys_clk) begin
        if (reset) begin
            last = 20'h0_0000;
            check("reset", {valid_r, remapped_r, region_r, mem_addr_r}, 21'h00_0000);
        end else if (valid_r === 1'b1) begin
            ex = (exp_q.size() > 0) ? exp_q.pop_front() : ~20'h0_0000;
            check("flags", 21'({valid_r, remapped_r}), 21'({1'b1, ex[19]}));
            check("address", 21'(mem_addr_r), 21'(ex[15:0]));
            check("region", 21'(region_r), 21'(ex[18:16]));
            last = ex;
        end else check("hold", {valid_r, remapped_r, region_r, mem_addr_r}, {1'b0, last});
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    // Main sequence
    initial begin
        reset = 1'b1;
        s = $urandom(32'h24c9_ce23);
        repeat (5) @(negedge sys_clk);
        reset <= 1'b0;
        // Every value of select bits 6:0 (bit 7 random) against window edges
        for (int w = 0; w < 128; w++)
            foreach (lows[i]) req({8'h00, lows[i]}, 1'b0, {1'($urandom_range(1)), 7'(w)}, 1'b1);
        // Map boundaries, fetch and access select
        for (int k = 0; k < 4; k++)
            foreach (bnd[i]) req(bnd[i], k[0], 8'h12, k[1]);
        // Random traffic with gaps
        repeat (400) begin
            ra = 16'($urandom);
            while (cpu_model_i.reserved(ra)) ra = 16'($urandom);
            req(ra, 1'($urandom), 8'($urandom), 1'($urandom));
            if ($urandom_range(3) == 0) cpu_model_i.idle();
        end
        // Reset in mid-run, then resume
        repeat (3) cpu_model_i.idle();
        reset <= 1'b1;
        repeat (3) @(negedge sys_clk);
        reset <= 1'b0;
        req(16'h00C5, 1'b0, 8'h12, 1'b0);
        req(16'h00FF, 1'b0, 8'h5F, 1'b0);
        // Fetch inside an open window stays unmapped and off-chip
        req(16'h00C5, 1'b1, 8'h12, 1'b0);
        repeat (3) cpu_model_i.idle();
        close_out();
    end
endmodule
